// ---- logic/fpm_pkg.sv ----
/*
  fpm_pkg: register map, control field positions, reset values, timing
  and carrier types of the program memory access controller.
  assumes an apb slave on pclk and a flash array port outside the block.
*/
package fpm_pkg;
  localparam logic [7:0] fpm_off_ctrl = 8'h00;
  localparam logic [7:0] fpm_off_unlock = 8'h04;
  localparam logic [7:0] fpm_off_latch = 8'h08;
  localparam logic [7:0] fpm_off_ptr = 8'h0c;
  localparam logic [7:0] fpm_off_op = 8'h10;
  localparam logic [7:0] fpm_off_pir = 8'h14;
  localparam logic [7:0] fpm_off_eedata = 8'h18;
  localparam int fpm_b_pgsel = 7;
  localparam int fpm_b_cfgsel = 6;
  localparam int fpm_b_erase = 4;
  localparam int fpm_b_err = 3;
  localparam int fpm_b_write_enable_bit = 2;
  localparam int fpm_b_wr = 1;
  localparam int fpm_b_rd = 0;
  localparam int fpm_b_done = 4;
  localparam logic [7:0] fpm_ctrl_rst = 8'h00;
  localparam logic [7:0] fpm_key1 = 8'h55;
  localparam logic [7:0] fpm_key2 = 8'haa;
  localparam int fpm_blk_bytes = 64;
  localparam int fpm_blk_bits = 6;
  localparam int fpm_ptr_bits = 22;
  localparam int fpm_clk_mhz = 250;
  localparam int fpm_prog_us = 2000;
  localparam int fpm_prog_cycles = fpm_prog_us * fpm_clk_mhz;
  localparam logic [1:0] fpm_tgt_eeprom = 2'd0;
  localparam logic [1:0] fpm_tgt_flash = 2'd1;
  localparam logic [1:0] fpm_tgt_config = 2'd2;
  typedef struct packed {
    logic rd;
    logic wr;
    logic erase;
    logic [1:0] target;
    logic [fpm_ptr_bits-1:0] addr;
  } fpm_req_type;
  typedef enum logic [1:0] {
    fpm_idle = 2'b00,
    fpm_busy = 2'b01,
    fpm_fin = 2'b11
  } fpm_state_type;
endpackage

// ---- logic/fpm_ctrl.sv ----
/*
  fpm_ctrl: byte access to 16-bit program flash, 64-byte holding block,
  control/status register with self-timed erase and write cycles.
  assumes an apb master on pclk, a flash array answering reads in the
  same cycle and taking a whole block on a write strobe.
*/
// The implementer's own choices: the placing of the registers and register access over APB.
module fpm_ctrl #(
  parameter int prog_cycles = fpm_pkg::fpm_prog_cycles
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash array
  output fpm_pkg::fpm_req_type arr_req,
  output logic [7:0] arr_wblock [fpm_pkg::fpm_blk_bytes],
  input wire logic [15:0] arr_rword,
  input wire logic [7:0] arr_rbyte_ee,
  // core
  output logic fetch_stall
);
  import fpm_pkg::*;

  logic [7:0] ctrl;
  logic [7:0] latch;
  logic [fpm_ptr_bits-1:0] ptr;
  logic [7:0] hold [fpm_blk_bytes];
  logic [7:0] ee_data;
  logic done_flag;
  logic [1:0] unlock;
  logic [31:0] timer;
  fpm_state_type state;
  logic wr_acc;
  logic start_ok;
  logic start_bad;
  logic timer_end;
  logic [7:0] wbyte;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // unmapped offsets answer with an error response
  function automatic logic reg_known(input logic [7:0] a);
    logic known;
    if (a == fpm_off_ctrl) begin
      known = 1'b1;
    end else if (a == fpm_off_unlock) begin
      known = 1'b1;
    end else if (a == fpm_off_latch) begin
      known = 1'b1;
    end else if (a == fpm_off_ptr) begin
      known = 1'b1;
    end else if (a == fpm_off_op) begin
      known = 1'b1;
    end else if (a == fpm_off_pir) begin
      known = 1'b1;
    end else if (a == fpm_off_eedata) begin
      known = 1'b1;
    end else begin
      known = 1'b0;
    end
    return known;
  endfunction

  // configuration space overrides the memory select
  function automatic logic [1:0] mem_target(input logic pg, input logic cfg);
    logic [1:0] t;
    if (cfg) begin
      t = fpm_tgt_config;
    end else if (pg) begin
      t = fpm_tgt_flash;
    end else begin
      t = fpm_tgt_eeprom;
    end
    return t;
  endfunction

  assign wr_acc = psel && penable && pwrite;
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  assign timer_end = state == fpm_busy && timer == 32'h00000000;

  assign start_ok = wr_acc && hit(paddr, fpm_off_ctrl) && wbyte[fpm_b_wr]
    && !ctrl[fpm_b_wr] && ctrl[fpm_b_write_enable_bit] && unlock == 2'd2;
  assign start_bad = wr_acc && hit(paddr, fpm_off_ctrl) && wbyte[fpm_b_wr]
    && !ctrl[fpm_b_wr] && !start_ok;

  // unlock sequence tracker; any other write breaks it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock <= 2'd0;
    end else if (wr_acc) begin
      if (hit(paddr, fpm_off_unlock) && wbyte == fpm_key1) begin
        unlock <= 2'd1;
      end else if (hit(paddr, fpm_off_unlock) && wbyte == fpm_key2
                   && unlock == 2'd1) begin
        unlock <= 2'd2;
      end else if (!(hit(paddr, fpm_off_ctrl) && unlock == 2'd2)) begin
        unlock <= 2'd0;
      end else begin
        unlock <= 2'd0;
      end
    end
  end

  // control register, one flop per field; bit 5 is unused and reads zero
  logic sel_pg;
  logic sel_cfg;
  logic erase_en;
  logic err_flag;
  logic write_enable_bit;
  logic wr_busy;
  logic rd_go;
  logic ctrl_wr;

  assign ctrl_wr = wr_acc && hit(paddr, fpm_off_ctrl);
  assign ctrl = {sel_pg, sel_cfg, 1'b0, erase_en, err_flag, write_enable_bit, wr_busy,
    rd_go};

  // keep selects on error
  // frozen mid-cycle too, so the target cannot move under a running cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_pg <= fpm_ctrl_rst[fpm_b_pgsel];
      sel_cfg <= fpm_ctrl_rst[fpm_b_cfgsel];
    end else if (ctrl_wr && !err_flag && !wr_busy) begin
      sel_pg <= wbyte[fpm_b_pgsel];
      sel_cfg <= wbyte[fpm_b_cfgsel];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_en <= fpm_ctrl_rst[fpm_b_erase];
    end else if (timer_end) begin
      erase_en <= 1'b0;
    end else if (ctrl_wr && !wr_busy) begin
      erase_en <= wbyte[fpm_b_erase];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_enable_bit <= fpm_ctrl_rst[fpm_b_write_enable_bit];
    end else if (ctrl_wr) begin
      write_enable_bit <= wbyte[fpm_b_write_enable_bit];
    end
  end

  // error flag
  // software may write it, but a start or an end of cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_flag <= fpm_ctrl_rst[fpm_b_err];
    end else if (start_ok || start_bad) begin
      err_flag <= 1'b1;
    end else if (timer_end) begin
      err_flag <= 1'b0;
    end else if (ctrl_wr) begin
      err_flag <= wbyte[fpm_b_err];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_busy <= fpm_ctrl_rst[fpm_b_wr];
    end else if (start_ok) begin
      wr_busy <= 1'b1;
    end else if (timer_end) begin
      wr_busy <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_go <= fpm_ctrl_rst[fpm_b_rd];
    end else if (ctrl_wr && wbyte[fpm_b_rd] && !sel_pg && !sel_cfg) begin
      rd_go <= 1'b1;
    end else begin
      rd_go <= 1'b0;
    end
  end

  // self-timed cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= fpm_idle;
      timer <= 32'h00000000;
    end else begin
      case (state)
        fpm_idle: begin
          if (start_ok) begin
            state <= fpm_busy;
            timer <= 32'(prog_cycles - 1);
          end
        end
        fpm_busy: begin
          if (timer == 32'h00000000) begin
            state <= fpm_fin;
          end else begin
            timer <= timer - 32'h00000001;
          end
        end
        fpm_fin: begin
          // a start landing in the end cycle must not be lost
          if (start_ok) begin
            state <= fpm_busy;
            timer <= 32'(prog_cycles - 1);
          end else begin
            state <= fpm_idle;
          end
        end
        default: begin
          state <= fpm_idle;
        end
      endcase
    end
  end

  assign fetch_stall = state == fpm_busy && ctrl[fpm_b_pgsel];

  // array request: write or erase pulse on timer end, read pulse from the rd bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arr_req <= '0;
    end else begin
      arr_req.wr <= timer_end && !ctrl[fpm_b_erase];
      arr_req.erase <= timer_end && ctrl[fpm_b_erase];
      arr_req.rd <= ctrl[fpm_b_rd];
      arr_req.target <= mem_target(ctrl[fpm_b_pgsel], ctrl[fpm_b_cfgsel]);
      arr_req.addr[fpm_ptr_bits-1:fpm_blk_bits] <=
        ptr[fpm_ptr_bits-1:fpm_blk_bits];
      // aligned blocks
      // low bits dropped on the strobe so the array cannot miss the block
      arr_req.addr[fpm_blk_bits-1:0] <= timer_end ? 6'h00 :
        ptr[fpm_blk_bits-1:0];
    end
  end

  // erase is per block only, no bulk command exists
  for (genvar i = 0; i < fpm_blk_bytes; i++) begin : g_hold
    assign arr_wblock[i] = hold[i];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hold[i] <= 8'hff;
      end else if (wr_acc && hit(paddr, fpm_off_op) && wbyte[1]
                   && ptr[fpm_blk_bits-1:0] == 6'(i)) begin
        hold[i] <= latch;
      end
    end
  end

  // table pointer and latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr <= '0;
    end else if (wr_acc && hit(paddr, fpm_off_ptr)) begin
      ptr <= pwdata[fpm_ptr_bits-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch <= 8'h00;
    end else if (wr_acc && hit(paddr, fpm_off_latch)) begin
      latch <= wbyte;
    end else if (wr_acc && hit(paddr, fpm_off_op) && wbyte[0]) begin
      latch <= ptr[0] ? arr_rword[15:8] : arr_rword[7:0];
    end
  end

  // eeprom read data captured during the one-cycle read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_data <= 8'h00;
    end else if (arr_req.rd) begin
      // taken while the array read strobe stands
      ee_data <= arr_rbyte_ee;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag <= 1'b0;
    end else if (timer_end) begin
      done_flag <= 1'b1;
    end else if (wr_acc && hit(paddr, fpm_off_pir)) begin
      done_flag <= wbyte[fpm_b_done];
    end
  end

  // read mux; unmapped addresses answer with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      if (hit(paddr, fpm_off_ctrl)) begin
        prdata <= {24'h000000, ctrl};
      end else if (hit(paddr, fpm_off_unlock)) begin
        prdata <= 32'h00000000;
      end else if (hit(paddr, fpm_off_latch)) begin
        prdata <= {24'h000000, latch};
      end else if (hit(paddr, fpm_off_ptr)) begin
        prdata <= {10'h000, ptr};
      end else if (hit(paddr, fpm_off_pir)) begin
        prdata <= {27'h0000000, done_flag, 4'h0};
      end else if (hit(paddr, fpm_off_eedata)) begin
        prdata <= {24'h000000, ee_data};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  assign pslverr = psel && penable && !reg_known(paddr);
endmodule

// ---- test/fpm_chk_sva.sv ----
/* fpm_chk: port checks of fpm_ctrl.
   assumes fpm_pkg and a short programming timer. */
module fpm_chk #(
  parameter int prog_cycles = 8
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  // array and core
  input wire fpm_pkg::fpm_req_type arr_req,
  input wire logic fetch_stall
);
  timeunit 1ns;
  timeprecision 1ps;
  import fpm_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam int stall_lo = prog_cycles;
  localparam int stall_hi = prog_cycles + 4;
  chk_unlock_zero: assert property (
    psel && penable && !pwrite && paddr == fpm_off_unlock |-> prdata == 0)
    else $error("unlock read not zero");
  chk_stall_hold: assert property (
    $rose(fetch_stall) |-> fetch_stall [*8])
    else $error("stall dropped early");
  chk_stall_ends: assert property (
    $rose(fetch_stall) |-> ##[stall_lo:stall_hi] (arr_req.wr || arr_req.erase))
    else $error("no program strobe after stall");
  chk_erase_stalled: assert property (
    arr_req.erase |-> $past(fetch_stall) || $past(fetch_stall, 2))
    else $error("erase without stall");
  chk_wr_pulse: assert property (
    arr_req.wr |=> !arr_req.wr)
    else $error("write strobe too long");
  chk_rd_pulse: assert property (
    arr_req.rd |=> !arr_req.rd)
    else $error("read strobe too long");
  chk_rd_target: assert property (
    arr_req.rd |-> arr_req.target == fpm_tgt_eeprom && !fetch_stall)
    else $error("read strobe on wrong target");
  chk_erase_excl: assert property (
    arr_req.erase |-> !arr_req.wr)
    else $error("erase and write together");
endmodule

bind fpm_ctrl fpm_chk #(.prog_cycles(prog_cycles)) u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .arr_req, .fetch_stall);

// ---- test/fpm_flash.sv ----
/* fpm_flash: program flash array model, 256 words.
   assumes one-cycle strobes from fpm_ctrl. */
module fpm_flash (
  // from controller
  input wire logic pclk,
  input wire fpm_pkg::fpm_req_type arr_req,
  input wire logic [7:0] arr_wblock [64],
  // to controller
  output logic [15:0] arr_rword,
  output logic [7:0] arr_rbyte_ee
);
  timeunit 1ns;
  timeprecision 1ps;
  import fpm_pkg::*;
  logic [15:0] mem [256];
  logic [7:0] widx;
  assign widx = arr_req.addr[8:1];
  assign arr_rword = mem[widx];
  // byte valid in read cycle only
  assign arr_rbyte_ee = arr_req.rd ? 8'h3c : 8'hc3;
  initial for (int i = 0; i < 256; i++) mem[i] = 16'(i * 257) ^ 16'ha53c;
  always @(posedge pclk)
    if ((arr_req.wr || arr_req.erase) && arr_req.target == fpm_tgt_flash)
      for (int k = 0; k < 32; k++)
        mem[{widx[7:5], 5'(k)}] <= arr_req.erase ? 16'hffff :
          {arr_wblock[2*k+1], arr_wblock[2*k]};
endmodule

// ---- test/tb_flash_program_memory_access.sv ----
/* tb_flash_program_memory_access: apb bench of fpm_ctrl with flash
   model; assumes zero-wait apb and a short timer. */
module tb_flash_program_memory_access;
  timeunit 1ns;
  timeprecision 1ps;
  import fpm_pkg::*;
  localparam int pc = 8;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, fetch_stall;
  fpm_req_type arr_req;
  logic [7:0] arr_wblock [fpm_blk_bytes];
  logic [15:0] arr_rword;
  logic [7:0] arr_rbyte_ee;
  logic [32:0] q [$];
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  logic [21:0] base;
  logic [7:0] dat [64];
  fpm_ctrl #(.prog_cycles(pc)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .arr_req,
    .arr_wblock, .arr_rword, .arr_rbyte_ee, .fetch_stall);
  fpm_flash model (.pclk, .arr_req, .arr_wblock, .arr_rword, .arr_rbyte_ee);
  initial forever #2 pclk = ~pclk;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [32:0] e, input logic [32:0] g);
    n_checks++;
    if (e[32] ? g[32] !== 1'b1 : g !== e) begin
      n_mismatch++;
      $display("Error read expected %h seen %h", e, g);
    end
  endtask
  task automatic cmp_stall(input logic e);
    n_checks++;
    if (fetch_stall !== e) begin
      n_mismatch++;
      $display("Error fetch_stall expected %b seen %b", e, fetch_stall);
    end
  endtask
  // hold the request until pready, release, let one edge pass
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic er);
    q.push_back({er, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic tr(input logic [21:0] p, input logic [7:0] e);
    wr(fpm_off_ptr, 32'(p));
    wr(fpm_off_op, 32'h1);
    rd(fpm_off_latch, 32'(e), 1'b0);
  endtask
  task automatic prog(input logic [31:0] c);
    wr(fpm_off_unlock, 32'(fpm_key1));
    wr(fpm_off_unlock, 32'(fpm_key2));
    wr(fpm_off_ctrl, c);
  endtask
  function automatic logic [7:0] eb(input logic [21:0] p);
    logic [15:0] w;
    w = 16'(p[8:1] * 257) ^ 16'ha53c;
    return p[0] ? w[15:8] : w[7:0];
  endfunction
  always @(posedge pclk)
    if (psel && penable && !pwrite && pready) cmp(q.pop_front(),
      {pslverr, prdata});
  // far above the fewer than a thousand cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(68168));
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(fpm_off_ctrl, 32'h0, 0);
    wr(fpm_off_unlock, 32'h55);
    rd(fpm_off_unlock, 32'h0, 0);
    rd(8'h1c, 32'h0, 1);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      base = 22'($urandom);
      tr(base, eb(base));
    end
    $display("table read test done");
    base = {16'($urandom), 6'h0};
    wr(fpm_off_ctrl, 32'h84);
    for (int k = 0; k < 64; k++) begin
      dat[k] = 8'($urandom);
      wr(fpm_off_latch, 32'(dat[k]));
      wr(fpm_off_ptr, 32'(base) + k);
      wr(fpm_off_op, 32'h2);
    end
    prog(32'h86);
    cmp_stall(1);
    wr(fpm_off_ctrl, 32'h0c);
    rd(fpm_off_ctrl, 32'h8e, 0);
    repeat (pc + 4) @(posedge pclk);
    cmp_stall(0);
    rd(fpm_off_ctrl, 32'h84, 0);
    rd(fpm_off_pir, 32'h10, 0);
    wr(fpm_off_pir, 32'h0);
    rd(fpm_off_pir, 32'h0, 0);
    for (int k = 1; k < 64; k += 9) tr(base + 22'(k), dat[k]);
    $display("block write test done");
    wr(fpm_off_ctrl, 32'h94);
    prog(32'h96);
    repeat (pc + 4) @(posedge pclk);
    rd(fpm_off_ctrl, 32'h84, 0);
    tr(base + 22'h5, 8'hff);
    wr(fpm_off_ctrl, 32'h86);
    cmp_stall(0);
    rd(fpm_off_ctrl, 32'h8c, 0);
    wr(fpm_off_ctrl, 32'h80);
    prog(32'h82);
    rd(fpm_off_ctrl, 32'h88, 0);
    $display("erase and refusal test done");
    wr(fpm_off_ctrl, 32'h0);
    wr(fpm_off_ctrl, 32'h0);
    wr(fpm_off_ctrl, 32'h1);
    rd(fpm_off_ctrl, 32'h0, 0);
    rd(fpm_off_eedata, 32'h3c, 0);
    wr(fpm_off_ctrl, 32'hc4);
    prog(32'hc6);
    repeat (pc + 4) @(posedge pclk);
    tr(base + 22'h9, 8'hff);
    $display("target test done");
    end_sim();
  end
endmodule
